// [verilog/tcc_pkg.sv]
// Constants for the two-channel timer capture/compare block.
// Assumes 32-bit APB data with one byte-wide register in the low bits of each word.
package tcc_pkg;

    // ----------------------------------------------------------------
    // Register byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_MAIN = 8'h00;
    localparam logic [7:0] ADDR_CNT_HI = 8'h04;
    localparam logic [7:0] ADDR_CNT_LO = 8'h08;
    localparam logic [7:0] ADDR_MOD_HI = 8'h0c;
    localparam logic [7:0] ADDR_MOD_LO = 8'h10;
    localparam logic [7:0] ADDR_CH0_CTRL = 8'h14;
    localparam logic [7:0] ADDR_CH0_HI = 8'h18;
    localparam logic [7:0] ADDR_CH0_LO = 8'h1c;
    localparam logic [7:0] ADDR_CH1_CTRL = 8'h20;
    localparam logic [7:0] ADDR_CH1_HI = 8'h24;
    localparam logic [7:0] ADDR_CH1_LO = 8'h28;

    // ----------------------------------------------------------------
    // Main control field positions
    // ----------------------------------------------------------------
    localparam int MAIN_OVF_BIT = 7;
    localparam int MAIN_IE_BIT = 6;
    localparam int MAIN_HALT_BIT = 5;
    localparam int MAIN_CLR_BIT = 4;
    localparam int MAIN_PS_MSB = 2;

    // ----------------------------------------------------------------
    // Channel control field positions
    // ----------------------------------------------------------------
    localparam int CH_FLAG_BIT = 7;
    localparam int CH_IE_BIT = 6;
    localparam int CH_BUF_BIT = 5;
    localparam int CH_MSA_BIT = 4;
    localparam int CH_ELH_BIT = 3;
    localparam int CH_ELL_BIT = 2;
    localparam int CH_TOV_BIT = 1;
    localparam int CH_MAX_BIT = 0;

    // ----------------------------------------------------------------
    // Reset values and encodings
    // ----------------------------------------------------------------
    localparam logic [15:0] MOD_RST = 16'hffff;
    localparam logic HALT_RST = 1'b1;
    localparam logic [2:0] PS_RST = 3'h0;
    localparam logic [2:0] PS_UNUSED = 3'h7;
    localparam logic [1:0] EL_OFF = 2'h0;
    localparam logic [1:0] EL_TOGGLE = 2'h1;
    localparam logic [1:0] EL_CLEAR = 2'h2;
    localparam logic [1:0] EL_SET = 2'h3;

endpackage

// [verilog/tcc_capture_compare.sv]
// Two-channel input capture / output compare / PWM timer with counter, prescaler and modulo.
// Assumes an APB master on CORE_CLK and channel pins from a pad ring (asynchronous inputs).
`timescale 1ns/100ps
module tcc_capture_compare #(
    parameter int NCH = 2
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RESET,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Channel pins
    input wire logic [1:0] CH_PIN_IN,
    output logic [1:0] CH_PIN_OUT,
    output logic [1:0] CH_PIN_OE_N,
    // Interrupt requests
    output logic [1:0] CH_IRQ,
    output logic OVF_IRQ
);

    // ----------------------------------------------------------------
    // Types and elaboration check
    // ----------------------------------------------------------------
    if (NCH != 2) begin : g_bad_nch
        $error("tcc_capture_compare: buffered pairing needs exactly two channels");
    end

    typedef enum logic [3:0] {
        TCC_R_NONE, TCC_R_MAIN, TCC_R_CNTH, TCC_R_CNTL, TCC_R_MODH, TCC_R_MODL,
        TCC_R_CTRL, TCC_R_VALH, TCC_R_VALL
    } tcc_reg_e;

    typedef struct packed {
        logic [15:0] cnt;
        logic [5:0] psc;
        logic halt;
        logic ovf_flag;
        logic ovf_armed;
        logic ovf_ie;
        logic [2:0] ps;
        logic [15:0] modv;
        logic mod_lock;
        logic [7:0] cnt_lo_hold;
        logic cnt_held;
        logic msb0;
        logic buf_sel;
        logic [NCH-1:0] flag;
        logic [NCH-1:0] armed;
        logic [NCH-1:0] ie;
        logic [NCH-1:0] msa;
        logic [NCH-1:0] tov;
        logic [NCH-1:0] maxd;
        logic [NCH-1:0] max_eff;
        logic [NCH-1:0] rd_lock;
        logic [NCH-1:0] wr_lock;
        logic [NCH-1:0] outv;
        logic [NCH-1:0] pin_s1;
        logic [NCH-1:0] pin_s2;
        logic [NCH-1:0] pin_prev;
        logic [NCH-1:0][1:0] els;
        logic [NCH-1:0][15:0] val;
        logic [31:0] prdata;
        logic pslverr;
    } tcc_state_s;

    tcc_state_s st_r;
    tcc_state_s st_nxt;
    logic tick;
    logic ovf_ev;
    logic [NCH-1:0] cap_ev;
    logic [NCH-1:0] cmp_ev;
    logic [NCH-1:0] ch_en;
    logic [NCH-1:0] ch_cap;
    logic [NCH-1:0] ch_cmp;
    logic acc_wr;
    logic acc_rd;
    tcc_reg_e acc_reg;
    logic acc_ch;

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    // Address to register kind; channel number comes from ch_of
    function automatic tcc_reg_e reg_of(input logic [7:0] a);
        case (a)
            tcc_pkg::ADDR_MAIN: reg_of = TCC_R_MAIN;
            tcc_pkg::ADDR_CNT_HI: reg_of = TCC_R_CNTH;
            tcc_pkg::ADDR_CNT_LO: reg_of = TCC_R_CNTL;
            tcc_pkg::ADDR_MOD_HI: reg_of = TCC_R_MODH;
            tcc_pkg::ADDR_MOD_LO: reg_of = TCC_R_MODL;
            tcc_pkg::ADDR_CH0_CTRL, tcc_pkg::ADDR_CH1_CTRL: reg_of = TCC_R_CTRL;
            tcc_pkg::ADDR_CH0_HI, tcc_pkg::ADDR_CH1_HI: reg_of = TCC_R_VALH;
            tcc_pkg::ADDR_CH0_LO, tcc_pkg::ADDR_CH1_LO: reg_of = TCC_R_VALL;
            default: reg_of = TCC_R_NONE;
        endcase
    endfunction

    function automatic logic ch_of(input logic [7:0] a);
        ch_of = (a >= tcc_pkg::ADDR_CH1_CTRL);
    endfunction

    // Prescaler mask: a tick when all low 'ps' bits of the divider are ones
    function automatic logic [5:0] psc_mask(input logic [2:0] ps);
        psc_mask = (6'h01 << ps) - 6'h01;
    endfunction

    // Channel control byte as software reads it
    function automatic logic [7:0] ctrl_byte(input tcc_state_s s, input int x);
        logic [7:0] b;
        b = 8'h00;
        b[tcc_pkg::CH_FLAG_BIT] = s.flag[x];
        b[tcc_pkg::CH_IE_BIT] = s.ie[x];
        b[tcc_pkg::CH_BUF_BIT] = (x == 0) ? s.msb0 : 1'b0;
        b[tcc_pkg::CH_MSA_BIT] = s.msa[x];
        b[tcc_pkg::CH_ELH_BIT] = s.els[x][1];
        b[tcc_pkg::CH_ELL_BIT] = s.els[x][0];
        b[tcc_pkg::CH_TOV_BIT] = s.tov[x];
        b[tcc_pkg::CH_MAX_BIT] = s.maxd[x];
        ctrl_byte = b;
    endfunction

    // ----------------------------------------------------------------
    // Bus access and channel mode decode
    // ----------------------------------------------------------------
    // Zero-wait slave: read data is prepared in the setup cycle
    assign acc_reg = reg_of(PADDR);
    assign acc_ch = ch_of(PADDR);
    assign acc_wr = PSEL && PENABLE && PWRITE && (acc_reg != TCC_R_NONE);
    assign acc_rd = PSEL && PENABLE && !PWRITE && (acc_reg != TCC_R_NONE);
    assign PREADY = 1'b1;
    assign PRDATA = st_r.prdata;
    assign PSLVERR = st_r.pslverr && PSEL && PENABLE;

    // Channel 1 capture, compare and pin drive are switched off while channel 0 runs buffered
    always_comb begin
        for (int x = 0; x < NCH; x++) begin
            ch_en[x] = (st_r.els[x] != tcc_pkg::EL_OFF) && !(x == 1 && st_r.msb0);
            ch_cap[x] = ch_en[x] && !st_r.msa[x] && !(x == 0 && st_r.msb0);
            ch_cmp[x] = ch_en[x] && (st_r.msa[x] || (x == 0 && st_r.msb0));
        end
    end

    // Pins and requests
    assign CH_PIN_OUT = st_r.outv;
    assign CH_PIN_OE_N = ~ch_cmp;
    assign CH_IRQ = st_r.flag & st_r.ie;
    assign OVF_IRQ = st_r.ovf_flag && st_r.ovf_ie;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    // Order: counting, software, then hardware events last, so a set beats a clear and a channel flag set cancels an armed clear
    always_comb begin
        logic [15:0] cval;
        logic rise;
        logic fall;
        logic hit;
        cval = 16'h0000;
        rise = 1'b0;
        fall = 1'b0;
        hit = 1'b0;
        st_nxt = st_r;
        cap_ev = '0;
        cmp_ev = '0;

        // Pin synchronisers; only the second stage feeds edge detection
        st_nxt.pin_s1 = CH_PIN_IN;
        st_nxt.pin_s2 = st_r.pin_s1;
        st_nxt.pin_prev = st_r.pin_s2;

        // Prescaler and counter
        tick = !st_r.halt && (st_r.ps != tcc_pkg::PS_UNUSED)
            && ((st_r.psc & psc_mask(st_r.ps)) == psc_mask(st_r.ps));
        ovf_ev = tick && (st_r.cnt == st_r.modv);
        if (!st_r.halt) begin
            st_nxt.psc = st_r.psc + 6'h01;
        end
        if (tick) begin
            st_nxt.cnt = ovf_ev ? 16'h0000 : st_r.cnt + 16'h0001;
        end
        if (ovf_ev) begin
            st_nxt.max_eff = st_r.maxd;
            if (st_r.msb0) begin
                st_nxt.buf_sel = !st_r.buf_sel;
            end
        end

        // Software reads: arm flag clears, latch split bytes
        if (acc_rd) begin
            case (acc_reg)
                TCC_R_MAIN: st_nxt.ovf_armed = st_r.ovf_flag;
                TCC_R_CNTH: begin
                    st_nxt.cnt_lo_hold = st_r.cnt[7:0];
                    st_nxt.cnt_held = 1'b1;
                end
                TCC_R_CNTL: st_nxt.cnt_held = 1'b0;
                TCC_R_CTRL: st_nxt.armed[acc_ch] = st_r.flag[acc_ch];
                TCC_R_VALH: st_nxt.rd_lock[acc_ch] = ch_cap[acc_ch];
                TCC_R_VALL: st_nxt.rd_lock[acc_ch] = 1'b0;
                default: ;
            endcase
        end

        // Software writes
        if (acc_wr) begin
            case (acc_reg)
                TCC_R_MAIN: begin
                    st_nxt.ovf_ie = PWDATA[tcc_pkg::MAIN_IE_BIT];
                    st_nxt.halt = PWDATA[tcc_pkg::MAIN_HALT_BIT];
                    st_nxt.ps = PWDATA[tcc_pkg::MAIN_PS_MSB:0];
                    if (st_r.ovf_armed && !PWDATA[tcc_pkg::MAIN_OVF_BIT]) begin
                        st_nxt.ovf_flag = 1'b0;
                    end
                    st_nxt.ovf_armed = 1'b0;
                    if (PWDATA[tcc_pkg::MAIN_CLR_BIT]) begin
                        st_nxt.cnt = 16'h0000;
                        st_nxt.psc = 6'h00;
                    end
                end
                TCC_R_MODH: begin
                    st_nxt.modv[15:8] = PWDATA[7:0];
                    st_nxt.mod_lock = 1'b1;
                end
                TCC_R_MODL: begin
                    st_nxt.modv[7:0] = PWDATA[7:0];
                    st_nxt.mod_lock = 1'b0;
                end
                TCC_R_CTRL: begin
                    // Channel 1 control ignores writes while channel 0 is buffered
                    if (!(acc_ch && st_r.msb0)) begin
                        st_nxt.ie[acc_ch] = PWDATA[tcc_pkg::CH_IE_BIT];
                        st_nxt.msa[acc_ch] = PWDATA[tcc_pkg::CH_MSA_BIT];
                        st_nxt.els[acc_ch] = PWDATA[tcc_pkg::CH_ELH_BIT:tcc_pkg::CH_ELL_BIT];
                        st_nxt.tov[acc_ch] = PWDATA[tcc_pkg::CH_TOV_BIT];
                        st_nxt.maxd[acc_ch] = PWDATA[tcc_pkg::CH_MAX_BIT];
                        if (st_r.armed[acc_ch] && !PWDATA[tcc_pkg::CH_FLAG_BIT]) begin
                            st_nxt.flag[acc_ch] = 1'b0;
                        end
                        st_nxt.armed[acc_ch] = 1'b0;
                        if (!acc_ch) begin
                            st_nxt.msb0 = PWDATA[tcc_pkg::CH_BUF_BIT];
                        end
                    end
                end
                TCC_R_VALH: begin
                    st_nxt.val[acc_ch][15:8] = PWDATA[7:0];
                    st_nxt.wr_lock[acc_ch] = ch_cmp[acc_ch] || (acc_ch && st_r.msb0);
                end
                TCC_R_VALL: begin
                    st_nxt.val[acc_ch][7:0] = PWDATA[7:0];
                    st_nxt.wr_lock[acc_ch] = 1'b0;
                end
                default: ;
            endcase
        end

        // Channel events and pin actions
        for (int x = 0; x < NCH; x++) begin
            cval = (x == 0 && st_r.msb0) ? st_r.val[st_r.buf_sel] : st_r.val[x];
            rise = st_r.pin_s2[x] && !st_r.pin_prev[x];
            fall = !st_r.pin_s2[x] && st_r.pin_prev[x];
            // Buffered compare is blocked while either half of the pair is mid-write
            hit = tick && (st_r.cnt == cval) && !st_r.wr_lock[x]
                && !(x == 0 && st_r.msb0 && st_r.wr_lock[1]);
            case (st_r.els[x])
                tcc_pkg::EL_TOGGLE: cap_ev[x] = rise;
                tcc_pkg::EL_CLEAR: cap_ev[x] = fall;
                tcc_pkg::EL_SET: cap_ev[x] = rise || fall;
                default: cap_ev[x] = 1'b0;
            endcase
            cap_ev[x] = cap_ev[x] && ch_cap[x] && !st_r.halt && !st_r.rd_lock[x];
            cmp_ev[x] = ch_cmp[x] && hit;
            if (cap_ev[x]) begin
                st_nxt.val[x] = st_r.cnt;
            end
            if (cap_ev[x] || cmp_ev[x]) begin
                st_nxt.flag[x] = 1'b1;
                st_nxt.armed[x] = 1'b0;
            end
            if (st_r.els[x] == tcc_pkg::EL_OFF) begin
                st_nxt.outv[x] = !st_r.msa[x];
            end else if (ch_cmp[x]) begin
                if (st_r.tov[x] && st_r.max_eff[x] && st_r.els[x] == tcc_pkg::EL_CLEAR) begin
                    st_nxt.outv[x] = 1'b1;
                end else if (ovf_ev && st_r.tov[x]) begin
                    st_nxt.outv[x] = !st_r.outv[x];
                end else if (cmp_ev[x]) begin
                    case (st_r.els[x])
                        tcc_pkg::EL_TOGGLE: st_nxt.outv[x] = !st_r.outv[x];
                        tcc_pkg::EL_CLEAR: st_nxt.outv[x] = 1'b0;
                        default: st_nxt.outv[x] = 1'b1;
                    endcase
                end
            end
        end
        if (ovf_ev && !st_r.mod_lock) begin
            st_nxt.ovf_flag = 1'b1;
        end

        // Read data for the access phase that follows this setup cycle
        if (PSEL && !PENABLE) begin
            st_nxt.prdata = 32'h0000_0000;
            st_nxt.pslverr = (reg_of(PADDR) == TCC_R_NONE);
            case (reg_of(PADDR))
                TCC_R_MAIN: st_nxt.prdata[7:0] = {st_r.ovf_flag, st_r.ovf_ie, st_r.halt, 2'b00, st_r.ps};
                TCC_R_CNTH: st_nxt.prdata[7:0] = st_r.cnt[15:8];
                TCC_R_CNTL: st_nxt.prdata[7:0] = st_r.cnt_held ? st_r.cnt_lo_hold : st_r.cnt[7:0];
                TCC_R_MODH: st_nxt.prdata[7:0] = st_r.modv[15:8];
                TCC_R_MODL: st_nxt.prdata[7:0] = st_r.modv[7:0];
                TCC_R_CTRL: st_nxt.prdata[7:0] = (ch_of(PADDR) && st_r.msb0) ? 8'h00
                    : ctrl_byte(st_r, int'(ch_of(PADDR)));
                TCC_R_VALH: st_nxt.prdata[7:0] = st_r.val[ch_of(PADDR)][15:8];
                TCC_R_VALL: st_nxt.prdata[7:0] = st_r.val[ch_of(PADDR)][7:0];
                default: st_nxt.prdata = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Value registers have no defined reset content; zero is used for tidiness
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            st_r <= '0;
            st_r.modv <= tcc_pkg::MOD_RST;
            st_r.halt <= tcc_pkg::HALT_RST;
            st_r.ps <= tcc_pkg::PS_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking tcc_cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RESET);

    AST_WRAP_TO_ZERO: assert property ((ovf_ev && !acc_wr) |=> st_r.cnt == 16'h0000)
        else $error("counter did not restart at zero after reaching modulo");
    AST_MOD_LOCK: assert property ((st_r.mod_lock && !st_r.ovf_flag) |=> !st_r.ovf_flag)
        else $error("overflow flag set while modulo update pending");
    AST_MOD_RESET: assert property ($past(RESET) |-> st_r.modv == 16'hffff && !st_r.mod_lock)
        else $error("modulo not at maximum after reset");
    AST_CAPTURE_FLAG: assert property (cap_ev[0] |=> st_r.flag[0] && st_r.val[0] == $past(st_r.cnt))
        else $error("capture did not set flag and store counter");
    AST_WRITE_ONE_KEEPS: assert property ((st_r.flag[0] && acc_wr && acc_reg == TCC_R_CTRL && !acc_ch
        && PWDATA[7]) |=> st_r.flag[0])
        else $error("writing one cleared a channel flag");
    AST_IRQ_GATED: assert property ($rose(CH_IRQ[0]) |-> st_r.ie[0] && st_r.flag[0])
        else $error("channel request without enable");
    AST_BUF_RELEASE: assert property (st_r.msb0 |-> CH_PIN_OE_N[1] && !cap_ev[1] && !cmp_ev[1])
        else $error("channel 1 active during buffered mode");
    AST_PRESET_LEVEL: assert property ((!$past(RESET) && $past(st_r.els[0]) == 2'h0 && st_r.els[0] == 2'h0)
        |-> CH_PIN_OUT[0] == !$past(st_r.msa[0]) && CH_PIN_OE_N[0])
        else $error("preset level or pin release wrong");
    AST_OVF_PRIORITY: assert property ((ovf_ev && cmp_ev[0] && st_r.tov[0] && !st_r.max_eff[0])
        |=> CH_PIN_OUT[0] == !$past(CH_PIN_OUT[0]))
        else $error("compare action overrode overflow toggle");
    AST_CAPTURE_HOLD: assert property ((st_r.rd_lock[0] && !acc_wr) |=> st_r.val[0] == $past(st_r.val[0]))
        else $error("capture while high byte read pending");
    AST_HALT_HOLDS: assert property ((st_r.halt && !acc_wr) |=> $stable(st_r.cnt))
        else $error("counter moved while halted");

endmodule

// [testbench/tcc_pin_model.sv]
// Far side of the two shared channel pins: the port logic and outside world.
// Assumes the channel releases a pin by raising its active-low output enable.
`timescale 1ns/100ps
module tcc_pin_model (
    // Levels the outside world would put on each pin
    input wire logic [1:0] lvl,
    // Channel output side
    input wire logic [1:0] out,
    input wire logic [1:0] oe_n,
    // Resolved pin level back to the channel
    output logic [1:0] pin_in
);
    // ------------------------------------------------------------
    // Pin resolution
    // ------------------------------------------------------------
    // A released pin follows the outside level, a driven one echoes the channel
    assign pin_in[0] = oe_n[0] ? lvl[0] : out[0];
    assign pin_in[1] = oe_n[1] ? lvl[1] : out[1];
endmodule

// [testbench/testbench.sv]
// Self-checking bench for the capture/compare timer block.
// Assumes a zero-wait APB slave and byte registers in the low data bits.
`timescale 1ns/100ps
module testbench;
    logic CORE_CLK = 1'b0;
    logic RESET = 1'b1;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic PREADY;
    logic PSLVERR;
    logic [1:0] CH_PIN_IN;
    logic [1:0] CH_PIN_OUT;
    logic [1:0] CH_PIN_OE_N;
    logic [1:0] CH_IRQ;
    logic OVF_IRQ;
    logic [1:0] lvl = 2'h0;
    logic [31:0] rd;
    logic err;
    logic [7:0] v;
    int miscompares = 0;
    int n_checks = 0;
    int cyc = 0;
    int seed = 32'h70986836;

    tcc_capture_compare #(.NCH(2)) u_dut (.CORE_CLK(CORE_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .CH_PIN_IN(CH_PIN_IN), .CH_PIN_OUT(CH_PIN_OUT), .CH_PIN_OE_N(CH_PIN_OE_N), .CH_IRQ(CH_IRQ),
        .OVF_IRQ(OVF_IRQ));
    tcc_pin_model u_pins (.lvl(lvl), .out(CH_PIN_OUT), .oe_n(CH_PIN_OE_N), .pin_in(CH_PIN_IN));

    // ------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ------------------------------------------------------------
    always #2.5 CORE_CLK = ~CORE_CLK;

    // A hung wait is cut short well past the expected run length
    always @(posedge CORE_CLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (miscompares == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; a free edge first keeps releases and setups apart
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge CORE_CLK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= {24'h0, d};
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        do @(posedge CORE_CLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    // Flag follows the code: only the falling-only code misses a rising edge
    function automatic logic [31:0] cap_exp(input logic [1:0] code);
        return {24'h0, code != 2'h2, 3'h0, code, 2'h0};
    endfunction

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge CORE_CLK);
        RESET <= 1'b0;
        apb(0, tcc_pkg::ADDR_MOD_HI, 8'h00); chk(rd, 32'hff);
        apb(0, tcc_pkg::ADDR_CH0_CTRL, 8'h00); chk(rd, 32'h00);
        chk({30'h0, CH_PIN_OE_N}, 32'h3);
        apb(0, 8'hfc, 8'h00); chk({31'h0, err}, 32'h1);
        // Short modulo, programmed high then low while stopped and cleared
        apb(1, tcc_pkg::ADDR_MAIN, 8'h30);
        apb(1, tcc_pkg::ADDR_MOD_HI, 8'h00);
        apb(1, tcc_pkg::ADDR_MOD_LO, 8'h10);
        apb(1, tcc_pkg::ADDR_MAIN, 8'h00);
        repeat (40) @(posedge CORE_CLK);
        apb(1, tcc_pkg::ADDR_MAIN, 8'h60);
        apb(0, tcc_pkg::ADDR_MAIN, 8'h00); chk(rd, 32'he0);
        chk({31'h0, OVF_IRQ}, 32'h1);
        apb(1, tcc_pkg::ADDR_MAIN, 8'h20);
        apb(0, tcc_pkg::ADDR_MAIN, 8'h00); chk(rd, 32'h20);
        // Clear-on-compare on channel 1 at a random value inside the modulo; preset level is high
        v = 8'h01 + 8'($unsigned($random(seed)) % 15);
        apb(1, tcc_pkg::ADDR_CH1_CTRL, 8'h58);
        apb(1, tcc_pkg::ADDR_CH1_HI, 8'h00);
        apb(1, tcc_pkg::ADDR_CH1_LO, v);
        apb(1, tcc_pkg::ADDR_MAIN, 8'h10);
        repeat (40) @(posedge CORE_CLK);
        chk({30'h0, CH_PIN_OE_N}, 32'h1);
        chk({31'h0, CH_PIN_OUT[1]}, 32'h0);
        chk({31'h0, CH_IRQ[1]}, 32'h1);
        // Capture codes on channel 0, each with a fresh rising edge
        for (int c = 1; c < 4; c++) begin
            lvl[0] <= 1'b0;
            repeat (10) @(posedge CORE_CLK);
            apb(0, tcc_pkg::ADDR_CH0_CTRL, 8'h00);
            apb(1, tcc_pkg::ADDR_CH0_CTRL, {4'h0, 2'(c), 2'h0});
            lvl[0] <= 1'b1;
            repeat (10) @(posedge CORE_CLK);
            apb(0, tcc_pkg::ADDR_CH0_CTRL, 8'h00); chk(rd, cap_exp(2'(c)));
        end
        // Buffered select on channel 0 takes channel 1 away
        apb(1, tcc_pkg::ADDR_CH0_CTRL, 8'h34);
        apb(0, tcc_pkg::ADDR_CH1_CTRL, 8'h00); chk(rd, 32'h00);
        chk({31'h0, CH_PIN_OE_N[1]}, 32'h1);
        // Buffered pair: the first value sits on the modulo, so every second overflow meets a match
        apb(1, tcc_pkg::ADDR_CH0_HI, 8'h00);
        apb(1, tcc_pkg::ADDR_CH0_LO, 8'h10);
        apb(1, tcc_pkg::ADDR_CH0_CTRL, 8'h3a);
        repeat (40) @(posedge CORE_CLK);
        // Full duty takes hold at the next overflow and then pins the output high
        apb(1, tcc_pkg::ADDR_CH0_CTRL, 8'h3b);
        repeat (40) @(posedge CORE_CLK);
        chk({31'h0, CH_PIN_OUT[0]}, 32'h1);
        end_of_test();
    end
endmodule
